/* iob_core_model.sv */
/*
  Core-side model: issues one register operation at a time to the bank.
  Assumes the bank takes a request at an edge that sees it idle.
*/
`timescale 1ns/10ps
`default_nettype none
module iob_core_model (
  input wire logic clk,
  input wire logic busy_reg,
  output logic req,
  output logic [2:0] op,
  output logic [6:0] addr,
  output logic dspace,
  output logic [2:0] bit_num,
  output logic [7:0] wdata
);
  // Quiet request lines from time zero
  initial begin
    req = 1'b0;
    op = 3'h0;
    addr = 7'h00;
    dspace = 1'b0;
    bit_num = 3'h0;
    wdata = 8'h00;
  end
  // Hold the request until an edge sees the bank idle; ok stays low on timeout
  task automatic issue(input logic [2:0] o, input logic [6:0] a, input logic d, input logic [2:0] b,
    input logic [7:0] w, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    req <= 1'b1;
    op <= o;
    addr <= a;
    dspace <= d;
    bit_num <= b;
    wdata <= w;
    // Busy is read before this edge's updates, as the bank sees it
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (busy_reg === 1'b0);
    end
    req <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* iob_decode.sv */
/*
  Address decode: folds the data-space alias onto I/O space, checks range and gives the
  implemented-bit mask and whether a register is fed from outside. Purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module iob_decode (
  input wire logic [6:0] addr,
  input wire logic dspace,
  input wire logic bit_op,
  output logic [5:0] idx,
  output logic hit,
  output logic [7:0] impl_mask,
  output logic ext
);
  // Implemented bits per register
  function automatic logic [7:0] impl_bits(input logic [5:0] i);
    case (i)
      iob_pkg::ADC_CONTROL_B_OFS, iob_pkg::TIMER0_CONTROL_B_OFS: impl_bits = iob_pkg::MASK_NO_B54;
      iob_pkg::COMPARATOR_CONTROL_B_OFS: impl_bits = iob_pkg::MASK_NO_B4;
      iob_pkg::PORT_C_INPUT_OFS, iob_pkg::PORT_C_DIRECTION_OFS, iob_pkg::PORT_C_OUTPUT_OFS,
      iob_pkg::PORT_C_PULLUP_OFS, iob_pkg::EEPROM_CONTROL_OFS, iob_pkg::PIN_CHANGE_MASK_2_OFS: impl_bits = iob_pkg::MASK_LOW6;
      iob_pkg::PORT_B_INPUT_OFS, iob_pkg::PORT_B_DIRECTION_OFS, iob_pkg::PORT_B_OUTPUT_OFS,
      iob_pkg::PORT_B_PULLUP_OFS, iob_pkg::SERIAL0_BAUD_HIGH_OFS, iob_pkg::PIN_CHANGE_MASK_1_OFS: impl_bits = iob_pkg::MASK_LOW4;
      iob_pkg::PORT_BREAK_BEFORE_MAKE_OFS: impl_bits = iob_pkg::MASK_LOW3;
      iob_pkg::TIMER0_CONTROL_A_OFS: impl_bits = iob_pkg::MASK_NO_B32;
      iob_pkg::EEPROM_ADDRESS_HIGH_OFS: impl_bits = iob_pkg::MASK_NONE;
      iob_pkg::SERIAL0_CONTROL_D_OFS: impl_bits = iob_pkg::MASK_TOP3;
      default: impl_bits = iob_pkg::MASK_ALL;
    endcase
  endfunction

  // Registers whose content comes from peripheral inputs, never from stores
  function automatic logic ext_reg(input logic [5:0] i);
    case (i)
      iob_pkg::ADC_RESULT_LOW_OFS, iob_pkg::ADC_RESULT_HIGH_OFS, iob_pkg::PORT_A_INPUT_OFS,
      iob_pkg::PORT_B_INPUT_OFS, iob_pkg::PORT_C_INPUT_OFS, iob_pkg::SHIFTER_BUFFER_OFS: ext_reg = 1'b1;
      default: ext_reg = 1'b0;
    endcase
  endfunction

  wire alias_sel = dspace && !bit_op;                   // Bit ops always name I/O addresses
  wire [6:0] io_addr = alias_sel ? (addr - iob_pkg::DSPACE_OFS) : addr;
  wire in_space = !alias_sel || (addr >= iob_pkg::DSPACE_OFS);
  wire bit_ok = !bit_op || (io_addr <= iob_pkg::BIT_OP_LAST);

  assign idx = io_addr[5:0];
  assign hit = in_space && (io_addr <= iob_pkg::IO_LAST) && bit_ok;
  assign impl_mask = impl_bits(io_addr[5:0]);
  assign ext = ext_reg(io_addr[5:0]);
endmodule
`default_nettype wire

/* iob_mem.sv */
/*
  Byte store of the register bank with per-bit write mask and registered read data.
  Assumes one write and one read address per cycle from the sequencer.
*/
`timescale 1ns/10ps
`default_nettype none
module iob_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wmask,
  input wire logic [7:0] wdata,
  input wire logic [5:0] raddr,
  output logic [7:0] rdata_reg
);
  logic [7:0] cells [iob_pkg::MEM_DEPTH];  // Register contents

  // Masked write keeps unselected bits, so single-bit writes stay single-bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < iob_pkg::MEM_DEPTH; i++) begin
        cells[i] <= iob_pkg::RESET_BYTE;
      end
      rdata_reg <= iob_pkg::RESET_BYTE;
    end else begin
      cells[waddr] <= (cells[waddr] & ~wmask) | (wdata & wmask);
      rdata_reg <= cells[raddr];
    end
  end
endmodule
`default_nettype wire

/* iob_pkg.sv */
/*
  Constants, register offsets, bit masks, operation codes and state codes for the
  lower I/O register bank. Assumes an 8-bit core that reaches the bank by I/O address
  or by its data-space alias.
*/
package iob_pkg;
  // Register offsets in I/O space
  localparam logic [5:0] ADC_RESULT_LOW_OFS = 6'h00, ADC_RESULT_HIGH_OFS = 6'h01, ADC_CONTROL_B_OFS = 6'h02,
    ADC_CONTROL_A_OFS = 6'h03, ADC_CHANNEL_SELECT_OFS = 6'h04, COMPARATOR_CONTROL_B_OFS = 6'h05,
    COMPARATOR_CONTROL_A_OFS = 6'h06, PORT_C_INPUT_OFS = 6'h07, PORT_C_DIRECTION_OFS = 6'h08,
    PORT_C_OUTPUT_OFS = 6'h09, PORT_C_PULLUP_OFS = 6'h0a, PORT_B_INPUT_OFS = 6'h0b, PORT_B_DIRECTION_OFS = 6'h0c,
    PORT_B_OUTPUT_OFS = 6'h0d, PORT_B_PULLUP_OFS = 6'h0e, PORT_A_INPUT_OFS = 6'h0f, PORT_A_DIRECTION_OFS = 6'h10,
    PORT_A_OUTPUT_OFS = 6'h11, PORT_A_PULLUP_OFS = 6'h12, PORT_BREAK_BEFORE_MAKE_OFS = 6'h13,
    GENERAL_SCRATCH_0_OFS = 6'h14, GENERAL_SCRATCH_1_OFS = 6'h15, GENERAL_SCRATCH_2_OFS = 6'h16,
    TIMER0_COMPARE_B_OFS = 6'h17, TIMER0_COMPARE_A_OFS = 6'h18, TIMER0_COUNT_OFS = 6'h19,
    TIMER0_CONTROL_B_OFS = 6'h1a, TIMER0_CONTROL_A_OFS = 6'h1b, EEPROM_CONTROL_OFS = 6'h1c,
    EEPROM_DATA_OFS = 6'h1d, EEPROM_ADDRESS_LOW_OFS = 6'h1e, EEPROM_ADDRESS_HIGH_OFS = 6'h1f,
    SERIAL0_DATA_OFS = 6'h20, SERIAL0_BAUD_LOW_OFS = 6'h21, SERIAL0_BAUD_HIGH_OFS = 6'h22,
    SERIAL0_CONTROL_D_OFS = 6'h23, SERIAL0_CONTROL_C_OFS = 6'h24, SERIAL0_CONTROL_B_OFS = 6'h25,
    SERIAL0_STATUS_A_OFS = 6'h26, PIN_CHANGE_MASK_0_OFS = 6'h27, PIN_CHANGE_MASK_1_OFS = 6'h28,
    PIN_CHANGE_MASK_2_OFS = 6'h29, SHIFTER_CONTROL_OFS = 6'h2a, SHIFTER_STATUS_OFS = 6'h2b,
    SHIFTER_DATA_OFS = 6'h2c, SHIFTER_BUFFER_OFS = 6'h2d;
  localparam logic [6:0] DSPACE_OFS = 7'h20;   // Data-space alias distance
  localparam logic [6:0] BIT_OP_LAST = 7'h1f;  // Highest bit-accessible I/O address
  localparam logic [6:0] IO_LAST = 7'h2d;      // Highest I/O address in this bank
  localparam int MEM_DEPTH = 64;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Implemented-bit masks; absent bits read zero and never store
  localparam logic [7:0] MASK_ALL = 8'hff, MASK_LOW3 = 8'h07, MASK_LOW4 = 8'h0f, MASK_LOW6 = 8'h3f,
    MASK_NONE = 8'h00, MASK_TOP3 = 8'he0, MASK_NO_B4 = 8'hef, MASK_NO_B54 = 8'hcf, MASK_NO_B32 = 8'hf3;
  // Write-one-to-clear status flags: register and bit position
  localparam int FLAG_N = 6;
  localparam logic [5:0] FLAG_OFS [FLAG_N] = '{ADC_CONTROL_A_OFS, COMPARATOR_CONTROL_A_OFS,
    SERIAL0_STATUS_A_OFS, SHIFTER_STATUS_OFS, SHIFTER_STATUS_OFS, SHIFTER_STATUS_OFS};
  localparam logic [2:0] FLAG_POS [FLAG_N] = '{3'h4, 3'h4, 3'h6, 3'h7, 3'h6, 3'h5};
  // Core operation codes
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_BIT_SET = 3'h2, OP_BIT_CLEAR = 3'h3,
    OP_SKIP_SET = 3'h4, OP_SKIP_CLEAR = 3'h5
  } iob_op_e;
  // Access sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FETCH = 2'b10
  } iob_state_e;
endpackage

/* iob_regs.sv */
/*
  Lower I/O register bank: byte reads and writes from the core at I/O or data-space
  addresses, single-bit set, clear and test on the lowest 32 I/O addresses, and
  write-one-to-clear status flags set by peripheral events. Peripheral behaviour lives
  elsewhere; this block only holds and presents register state. Inputs are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module iob_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [2:0] op,
  input wire logic [6:0] addr,
  input wire logic dspace,
  input wire logic [2:0] bit_num,
  input wire logic [7:0] wdata,
  input wire logic [15:0] adc_result,
  input wire logic [7:0] pin_a,
  input wire logic [3:0] pin_b,
  input wire logic [5:0] pin_c,
  input wire logic [7:0] shifter_buffer,
  input wire logic [5:0] flag_set,
  output logic busy_reg,
  output logic done_reg,
  output logic refused_reg,
  output logic [7:0] rd_data_reg,
  output logic skip_reg,
  output logic [5:0] flag_reg
);
  iob_pkg::iob_state_e state_reg, state_next;  // Access sequencer
  iob_pkg::iob_op_e op_reg;                    // Operation held across the fetch
  logic [5:0] idx_reg;                         // Decoded index held across the fetch
  logic hit_reg;                               // Address was valid
  logic [7:0] impl_reg;                        // Implemented bits of the fetched register
  logic ext_reg;                               // Fetched register is fed from inputs
  logic [2:0] bit_reg;                         // Bit under test
  logic [5:0] flag_next;
  logic [7:0] mem_q;                           // Registered store read data

  // Flag bits of register i as a byte, from flag vector f
  function automatic logic [7:0] flag_bits(input logic [5:0] i, input logic [5:0] f);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < iob_pkg::FLAG_N; k++) begin
      if (i == iob_pkg::FLAG_OFS[k]) begin
        b[iob_pkg::FLAG_POS[k]] = f[k];
      end
    end
    return b;
  endfunction

  // Operation classes
  wire is_idle = (state_reg == iob_pkg::ST_IDLE);
  wire accept = req && is_idle;                  // Request taken only when idle
  wire op_write = (op == iob_pkg::OP_WRITE);
  wire op_set = (op == iob_pkg::OP_BIT_SET);
  wire op_clr = (op == iob_pkg::OP_BIT_CLEAR);
  wire op_skip = (op == iob_pkg::OP_SKIP_SET) || (op == iob_pkg::OP_SKIP_CLEAR);
  wire op_read = (op == iob_pkg::OP_READ) || op_skip;
  wire op_bit = op_set || op_clr || op_skip;
  wire op_known = op_read || op_write || op_set || op_clr;

  // Address decode
  logic [5:0] dec_idx;
  logic dec_hit;
  logic [7:0] dec_impl;
  logic dec_ext;
  iob_decode u_decode (
    .addr(addr),
    .dspace(dspace),
    .bit_op(op_bit),
    .idx(dec_idx),
    .hit(dec_hit),
    .impl_mask(dec_impl),
    .ext(dec_ext)
  );

  // Store write mask: never flag bits, input-fed registers or absent bits
  wire [7:0] flag_mask = flag_bits(dec_idx, 6'h3f);
  wire [7:0] store_mask = dec_ext ? 8'h00 : (dec_impl & ~flag_mask);
  wire [7:0] bit_sel = 8'h01 << bit_num;
  wire do_wr = accept && dec_hit && (op_write || op_set || op_clr);
  // Bit operations write one bit only, so neighbouring flags see nothing
  wire [7:0] mem_wmask = !do_wr ? 8'h00 : (op_write ? store_mask : (store_mask & bit_sel));
  wire [7:0] mem_wdata = op_write ? wdata : (op_set ? 8'hff : 8'h00);

  iob_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .waddr(dec_idx),
    .wmask(mem_wmask),
    .wdata(mem_wdata),
    .raddr(dec_idx),
    .rdata_reg(mem_q)
  );

  // Clear requests per flag: a written one, or a bit set naming the flag
  logic [5:0] flag_clr;
  generate
    for (genvar k = 0; k < iob_pkg::FLAG_N; k++) begin : g_flag
      wire wr_one = op_write && wdata[iob_pkg::FLAG_POS[k]];
      wire set_one = op_set && (bit_num == iob_pkg::FLAG_POS[k]);
      // Bit clear writes a zero and so leaves the flag alone
      assign flag_clr[k] = accept && dec_hit && (dec_idx == iob_pkg::FLAG_OFS[k]) && (wr_one || set_one);
    end
  endgenerate
  // Hardware event wins over a clear in the same cycle
  assign flag_next = flag_set | (flag_reg & ~flag_clr);

  // Read value during the fetch cycle
  logic [7:0] ext_val;
  always_comb begin
    case (idx_reg)
      iob_pkg::ADC_RESULT_LOW_OFS: ext_val = adc_result[7:0];
      iob_pkg::ADC_RESULT_HIGH_OFS: ext_val = adc_result[15:8];
      iob_pkg::PORT_A_INPUT_OFS: ext_val = pin_a;
      iob_pkg::PORT_B_INPUT_OFS: ext_val = {4'h0, pin_b};
      iob_pkg::PORT_C_INPUT_OFS: ext_val = {2'h0, pin_c};
      iob_pkg::SHIFTER_BUFFER_OFS: ext_val = shifter_buffer;
      default: ext_val = 8'h00;
    endcase
  end
  // Absent and reserved bits read as zero; unmapped reads give zero
  wire [7:0] raw_val = ext_reg ? ext_val : (mem_q | flag_bits(idx_reg, flag_reg));
  wire [7:0] rd_val = hit_reg ? (raw_val & impl_reg) : 8'h00;
  wire sel_bit = rd_val[bit_reg];
  // Skip when the tested bit matches the requested sense
  wire skip_val = hit_reg && (sel_bit == (op_reg == iob_pkg::OP_SKIP_SET));
  wire in_fetch = (state_reg == iob_pkg::ST_FETCH);

  // Next state: reads take one fetch cycle, writes finish on acceptance
  always_comb begin
    case (state_reg)
      iob_pkg::ST_IDLE: state_next = (accept && op_read) ? iob_pkg::ST_FETCH : iob_pkg::ST_IDLE;
      iob_pkg::ST_FETCH: state_next = iob_pkg::ST_IDLE;
      default: state_next = iob_pkg::ST_IDLE;
    endcase
  end

  // Sequencer and held request fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= iob_pkg::ST_IDLE;
      op_reg <= iob_pkg::OP_READ;
      idx_reg <= 6'h00;
      hit_reg <= 1'b0;
      impl_reg <= 8'h00;
      ext_reg <= 1'b0;
      bit_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        op_reg <= iob_pkg::iob_op_e'(op);
        idx_reg <= dec_idx;
        hit_reg <= dec_hit;
        impl_reg <= dec_impl;
        ext_reg <= dec_ext;
        bit_reg <= bit_num;
      end
    end
  end

  // Answer outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      skip_reg <= 1'b0;
      flag_reg <= 6'h00;
    end else begin
      busy_reg <= (state_next == iob_pkg::ST_FETCH);
      done_reg <= in_fetch || (accept && !op_read);
      // Out-of-range or unknown requests change nothing and say so
      refused_reg <= accept && (!dec_hit || !op_known);
      flag_reg <= flag_next;
      if (in_fetch) begin
        rd_data_reg <= rd_val;
        skip_reg <= skip_val;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_bit_high_refused: assert property (accept && op_bit && (addr > 7'h1f) |=> refused_reg)
    else $error("bit operation above 0x1f not refused");
  a_bit_low_taken: assert property (accept && op_set && (addr <= 7'h1f) |=> done_reg && !refused_reg)
    else $error("bit set in low range not carried out");
  a_bit_single_lane: assert property (accept && (op_set || op_clr) |-> $onehot0(mem_wmask))
    else $error("bit operation wrote more than one bit");
  a_refused_no_write: assert property (accept && !dec_hit |-> (mem_wmask == 8'h00) && (flag_clr == 6'h00))
    else $error("refused access changed state");
  a_flag_w1c_clear: assert property (accept && op_write && dec_hit && (dec_idx == 6'h03) && wdata[4]
    && !flag_set[0] |=> !flag_reg[0])
    else $error("written one did not clear flag");
  a_flag_set_wins: assert property (flag_set[0] |=> flag_reg[0])
    else $error("flag event lost");
  a_clear_keeps_flag: assert property (flag_reg[0] && accept && op_clr && (addr == 7'h03) |=> flag_reg[0])
    else $error("bit clear disturbed a flag");
  a_skip_answer: assert property (accept && op_skip |=> busy_reg ##1 done_reg && (skip_reg == $past(skip_val)))
    else $error("skip result wrong or late");
  a_alias_index: assert property (accept && !op_bit && dspace && (addr >= 7'h20) && (addr <= 7'h4d)
    |-> dec_hit && (dec_idx == addr[5:0] - 6'h20))
    else $error("data-space alias decoded wrongly");

  // Answer timing: reads and tests take a fetch cycle, the rest answer at once
  // Read or test: busy for one cycle, then done
  a_read_two_cycle: assert property (
    accept && op_read
    |=> busy_reg && !done_reg ##1 done_reg && !busy_reg)
    else $error("read answer late");

  // Writes, bit sets and bit clears never fetch
  a_write_one_cycle: assert property (
    accept && !op_read
    |=> done_reg && !busy_reg)
    else $error("write answer late");

  // Busy never stretches past the single fetch cycle
  a_busy_single: assert property (
    busy_reg
    |=> !busy_reg)
    else $error("busy held too long");

  // Every fetch ends in a done pulse
  a_done_after_fetch: assert property (
    in_fetch
    |=> done_reg)
    else $error("fetch without answer");

  // Bit clear in the low range is carried out
  a_clear_low_taken: assert property (
    accept && op_clr && (addr <= iob_pkg::BIT_OP_LAST)
    |=> done_reg && !refused_reg)
    else $error("bit clear in low range refused");

  // Bit tests in the low range are answered, not refused
  a_skip_low_taken: assert property (
    accept && op_skip && (addr <= iob_pkg::BIT_OP_LAST)
    |=> !refused_reg ##1 done_reg)
    else $error("bit test in low range refused");

  // Skip-if-set reports the tested bit itself
  a_skip_set_sense: assert property (
    in_fetch && hit_reg && (op_reg == iob_pkg::OP_SKIP_SET)
    |=> skip_reg == rd_data_reg[bit_reg])
    else $error("skip-if-set sense wrong");

  // Skip-if-clear reports the inverse of the tested bit
  a_skip_clear_sense: assert property (
    in_fetch && hit_reg && (op_reg == iob_pkg::OP_SKIP_CLEAR)
    |=> skip_reg != rd_data_reg[bit_reg])
    else $error("skip-if-clear sense wrong");

  // Refused fetches hand back zero and never skip
  a_refused_read_zero: assert property (
    in_fetch && !hit_reg
    |=> (rd_data_reg == 8'h00) && !skip_reg)
    else $error("refused read returned data");

  // Read data and skip hold between fetches
  a_answer_holds: assert property (
    !in_fetch
    |=> $stable(rd_data_reg) && $stable(skip_reg))
    else $error("read answer changed unasked");

  // Bit operations above the low range touch nothing
  a_high_bit_nowrite: assert property (
    accept && op_bit && (addr > iob_pkg::BIT_OP_LAST)
    |-> (mem_wmask == 8'h00) && (flag_clr == 6'h00))
    else $error("high bit operation wrote");

  // I/O addresses beyond the bank are refused
  a_io_above_refused: assert property (
    accept && !dspace && (addr > iob_pkg::IO_LAST)
    |=> refused_reg)
    else $error("access beyond bank not refused");

  // Bit operations name the I/O address whatever dspace says
  a_bit_io_address: assert property (
    accept && op_bit && (addr <= iob_pkg::BIT_OP_LAST)
    |-> dec_hit && (dec_idx == addr[5:0]))
    else $error("bit operation address decoded wrongly");

  // Data-space addresses below the alias window are refused
  a_alias_low_refused: assert property (
    accept && !op_bit && dspace && (addr < iob_pkg::DSPACE_OFS)
    |=> refused_reg)
    else $error("alias below window not refused");

  // Bit set only ever writes ones
  a_set_writes_ones: assert property (
    accept && dec_hit && op_set
    |-> (mem_wmask & ~mem_wdata) == 8'h00)
    else $error("bit set wrote a zero");

  // Bit clear only ever writes zeros
  a_clr_writes_zeros: assert property (
    accept && dec_hit && op_clr
    |-> (mem_wmask & mem_wdata) == 8'h00)
    else $error("bit clear wrote a one");

  // The written lane is the named bit and no other
  a_bit_lane_match: assert property (
    accept && (op_set || op_clr)
    |-> (mem_wmask & ~(8'h01 << bit_num)) == 8'h00)
    else $error("bit operation wrote another lane");

  // Flag positions never reach the store
  a_flags_not_stored: assert property (
    accept
    |-> (mem_wmask & flag_mask) == 8'h00)
    else $error("flag bit written to store");

  // Bit clear never clears a flag
  a_clear_no_flag: assert property (
    accept && op_clr
    |-> flag_clr == 6'h00)
    else $error("bit clear cleared a flag");

  // Bit set on a flag position clears that flag
  a_set_clears_flag: assert property (
    accept && op_set && (addr == 7'h03) && (bit_num == 3'h4) && !flag_set[0]
    |=> !flag_reg[0])
    else $error("bit set did not clear flag");

  // Bit set on a neighbour leaves the flag alone
  a_set_other_bit: assert property (
    flag_reg[0] && accept && op_set && (addr == 7'h03) && (bit_num != 3'h4)
    |=> flag_reg[0])
    else $error("bit set on neighbour cleared flag");

  // Without event or clear a flag keeps its level
  a_flag_holds: assert property (
    !flag_set[0] && !flag_clr[0]
    |=> $stable(flag_reg[0]))
    else $error("flag changed without cause");

  c_bit_set: cover property (accept && op_set && dec_hit);
  c_skip_taken: cover property (in_fetch && skip_val && (op_reg == iob_pkg::OP_SKIP_CLEAR));
  c_flag_clear: cover property (flag_reg[0] ##1 !flag_reg[0]);
  c_refused: cover property (refused_reg);
  c_alias_read: cover property (accept && op_read && dspace && dec_hit);
endmodule
`default_nettype wire

/* iob_regs_tb.sv */
/*
  Self-checking bench for the lower I/O register bank.
  Assumes iob_core_model drives the request side; pins and flag events come from here.
*/
`timescale 1ns/10ps
`default_nettype none
module iob_regs_tb;
  typedef struct {logic rf; logic cd; logic cs; logic [7:0] d; logic s;} iob_exp_s; // One expected answer
  // Full-byte stored registers; 0x1f is never written
  localparam logic [6:0] RW_LIST [13] = '{7'h10, 7'h11, 7'h12, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19,
    7'h1d, 7'h1e, 7'h20, 7'h2c};
  logic clk, nrst, req, dspace, busy_reg, done_reg, refused_reg, skip_reg;
  logic [2:0] op, bit_num, b;
  logic [6:0] addr;
  logic [7:0] wdata, pin_a, shifter_buffer, rd_data_reg, v;
  logic [15:0] adc_result;
  logic [3:0] pin_b;
  logic [5:0] pin_c, flag_set, flag_reg;
  logic [63:0] r;
  logic [7:0] mirror [64]; // Expected stored byte per I/O address
  iob_exp_s exp_q [$]; // Notes from driver to watcher
  iob_exp_s e;
  int error_cnt, checks_done, i;
  integer seed;
  iob_regs i_iob_regs (.clk(clk), .nrst(nrst), .req(req), .op(op), .addr(addr), .dspace(dspace),
    .bit_num(bit_num), .wdata(wdata), .adc_result(adc_result), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c),
    .shifter_buffer(shifter_buffer), .flag_set(flag_set), .busy_reg(busy_reg), .done_reg(done_reg),
    .refused_reg(refused_reg), .rd_data_reg(rd_data_reg), .skip_reg(skip_reg), .flag_reg(flag_reg));
  iob_core_model i_iob_core_model (.clk(clk), .busy_reg(busy_reg), .req(req), .op(op), .addr(addr),
    .dspace(dspace), .bit_num(bit_num), .wdata(wdata));
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic mism(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Note first, then request, so the watcher never runs ahead
  task automatic go(input logic [2:0] o, input logic [6:0] a, input logic d, input logic [2:0] bn,
    input logic [7:0] w, input iob_exp_s x);
    logic ok;
    exp_q.push_back(x);
    i_iob_core_model.issue(o, a, d, bn, w, ok);
    if (!ok) begin
      mism("request never taken");
      close_out();
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic d, input logic [7:0] w);
    mirror[a[5:0]] = w;
    go(3'h1, a + (d ? 7'h20 : 7'h00), d, 3'h0, w, '{1'b0, 1'b0, 1'b0, 8'h00, 1'b0});
  endtask
  task automatic rd(input logic [6:0] a, input logic d);
    go(3'h0, a + (d ? 7'h20 : 7'h00), d, 3'h0, 8'h00, '{1'b0, 1'b1, 1'b0, mirror[a[5:0]], 1'b0});
  endtask
  task automatic bop(input logic [6:0] a, input logic [2:0] bn, input logic s);
    mirror[a[5:0]][bn] = s;
    go(s ? 3'h2 : 3'h3, a, 1'b0, bn, 8'h00, '{1'b0, 1'b0, 1'b0, 8'h00, 1'b0});
  endtask
  // Both skip tests; one of them must skip
  task automatic tst(input logic [6:0] a, input logic [2:0] bn);
    go(3'h4, a, 1'b0, bn, 8'h00, '{1'b0, 1'b1, 1'b1, mirror[a[5:0]], mirror[a[5:0]][bn]});
    go(3'h5, a, 1'b0, bn, 8'h00, '{1'b0, 1'b1, 1'b1, mirror[a[5:0]], ~mirror[a[5:0]][bn]});
  endtask
  // Wrong data and a live bit number, so a missed refusal would show
  task automatic rej(input logic [2:0] o, input logic [6:0] a, input logic d);
    go(o, a, d, 3'h1, 8'hff, '{1'b1, 1'b0, 1'b0, 8'h00, 1'b0});
  endtask
  // Flag is a level: let two edges land first
  task automatic fchk(input int k, input logic x);
    repeat (2) @(posedge clk);
    #1;
    checks_done++;
    if (flag_reg[k] !== x) mism("flag level");
  endtask
  task automatic fpulse(input int k);
    @(posedge clk);
    flag_set <= 6'h01 << k;
    @(posedge clk);
    flag_set <= 6'h00;
  endtask
  // Watcher: each answer pulse takes the oldest note
  always @(posedge clk) begin
    if (nrst === 1'b1 && (done_reg === 1'b1 || refused_reg === 1'b1)) begin
      checks_done++;
      if (exp_q.size() == 0) begin
        mism("answer with nothing pending");
      end else begin
        e = exp_q.pop_front();
        if (refused_reg !== e.rf || (e.cd && rd_data_reg !== e.d) || (e.cs && skip_reg !== e.s)) begin
          mism("answer differs from note");
        end
      end
    end
  end
  initial begin
    seed = 32'hb3ef;
    clk = 1'b0;
    nrst = 1'b0;
    flag_set = 6'h00;
    {adc_result, pin_a, pin_b, pin_c, shifter_buffer} = 42'h0;
    error_cnt = 0;
    checks_done = 0;
    for (i = 0; i < 64; i++) mirror[i] = 8'h00;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 13; i++) rd(RW_LIST[i], 1'b0);
    // Input-fed registers follow the live pins
    r = {$random(seed), $random(seed)};
    {adc_result, pin_a, pin_b, pin_c, shifter_buffer} <= r[41:0];
    repeat (3) @(posedge clk);
    mirror[0] = adc_result[7:0];
    mirror[1] = adc_result[15:8];
    mirror[7] = {2'b00, pin_c};
    mirror[11] = {4'h0, pin_b};
    mirror[15] = pin_a;
    mirror[45] = shifter_buffer;
    foreach (mirror[j]) if (j < 2 || j == 7 || j == 11 || j == 15 || j == 45) rd(7'(j), j[0]);
    tst(7'h0f, r[2:0]);
    // Write through one alias, read through the other
    for (i = 0; i < 13; i++) wr(RW_LIST[i], i[0], 8'($random(seed)));
    for (i = 0; i < 13; i++) rd(RW_LIST[i], ~i[0]);
    v = 8'($random(seed));
    wr(7'h0d, 1'b1, v & 8'h0f);
    rd(7'h0d, 1'b0);
    for (i = 0; i < 24; i++) begin
      v = 8'($random(seed));
      b = v[2:0];
      bop(RW_LIST[v[6:3] % 11], b, v[7]);
      tst(RW_LIST[v[6:3] % 11], b);
    end
    // Neighbours of every touched bit kept their values
    for (i = 0; i < 11; i++) rd(RW_LIST[i], 1'b0);
    rej(3'h2, 7'h20, 1'b0);
    rej(3'h3, 7'h2c, 1'b0);
    rd(7'h20, 1'b0);
    rd(7'h2c, 1'b0);
    rej(3'h6, 7'h14, 1'b0);
    rej(3'h7, 7'h14, 1'b0);
    rej(3'h1, 7'h14, 1'b1);
    rd(7'h14, 1'b0);
    // Sticky flag survives bit ops on other bits and a clear, dies on a bit set; another survives a written zero, dies on a written one
    fpulse(0);
    fchk(0, 1'b1);
    bop(7'h03, 3'h0, 1'b1);
    bop(7'h03, 3'h4, 1'b0);
    fchk(0, 1'b1);
    go(3'h4, 7'h03, 1'b0, 3'h4, 8'h00, '{1'b0, 1'b0, 1'b1, 8'h00, 1'b1});
    bop(7'h03, 3'h4, 1'b1);
    fchk(0, 1'b0);
    fpulse(2);
    wr(7'h26, 1'b1, 8'h00);
    fchk(2, 1'b1);
    wr(7'h26, 1'b0, 8'h40);
    fchk(2, 1'b0);
    // Other flags: bit set clears one, a byte write clears only its ones
    fpulse(1);
    fpulse(3);
    fpulse(5);
    fchk(1, 1'b1);
    bop(7'h06, 3'h4, 1'b1);
    fchk(1, 1'b0);
    wr(7'h2b, 1'b0, 8'h20);
    fchk(3, 1'b1);
    fchk(5, 1'b0);
    go(3'h0, 7'h2b, 1'b0, 3'h0, 8'h00, '{1'b0, 1'b1, 1'b0, 8'h80, 1'b0});
    repeat (4) @(posedge clk);
    checks_done++;
    if (exp_q.size() != 0) mism("answers missing");
    close_out();
  end
endmodule
`default_nettype wire
